// ### include/tapo_pkg.sv
// Package for the two-axis pulse output stage: map, layouts, constants
package tapo_pkg;

  // Axis select codes
  localparam logic [1:0] AXIS_FIRST_CODE  = 2'h1;
  localparam logic [1:0] AXIS_SECOND_CODE = 2'h2;
  localparam logic [1:0] BOTH_AXES_CODE   = 2'h3;

  // Register byte offsets
  localparam logic [7:0] OFS_COMMAND = 8'h00;
  localparam logic [7:0] OFS_MAXV0   = 8'h04;
  localparam logic [7:0] OFS_MAXV1   = 8'h08;
  localparam logic [7:0] OFS_SPEED0  = 8'h0C;
  localparam logic [7:0] OFS_SPEED1  = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_SCALE0  = 8'h18;
  localparam logic [7:0] OFS_SCALE1  = 8'h1C;

  // Command word field positions
  localparam int CMD_AXIS_LSB  = 0;
  localparam int CMD_OP_LSB    = 4;
  localparam int CMD_ARG_LSB   = 8;

  // Command opcodes
  localparam logic [3:0] OP_NONE    = 4'h0;
  localparam logic [3:0] OP_MODE    = 4'h1;
  localparam logic [3:0] OP_MAXV    = 4'h2;
  localparam logic [3:0] OP_MOVE    = 4'h3;
  localparam logic [3:0] OP_STOP    = 4'h4;
  localparam logic [3:0] OP_INTERP  = 4'h5;
  localparam logic [3:0] OP_RESET   = 4'hF;

  // Speed scaling
  localparam logic [31:0] PPS_PER_UNIT   = 32'h0000_1F40;  // 8000
  localparam logic [31:0] MAXV_LIMIT     = 32'h003D_0900;  // 4,000,000
  localparam logic [31:0] MAXV_RESET     = 32'h0000_1F40;
  localparam logic [9:0]  SCALE_RESET    = 10'h001;
  localparam logic [2:0]  MODE_RESET     = 3'h0;

  // Accumulator base: the 40 MHz clock rate, so one unit of rate is one pulse per second
  localparam int unsigned CLOCK_HZ       = 40000000;
  localparam logic [31:0] ACC_MODULUS    = 32'(CLOCK_HZ);

  // Direction setup before first step
  localparam int unsigned DIR_SETUP_NS   = 250;
  localparam int unsigned CLOCK_NS       = 25;
  localparam logic [3:0]  DIR_SETUP_CYC  = 4'((DIR_SETUP_NS + CLOCK_NS - 1) / CLOCK_NS);
  // Step pulse width
  localparam logic [3:0]  PULSE_CYC      = 4'h8;

  // Per axis channel state
  typedef enum logic [1:0] {
    TAPO_IDLE  = 2'b00,
    TAPO_SETUP = 2'b01,
    TAPO_RUN   = 2'b10
  } tapo_state_e;

  typedef struct packed {
    logic [2:0]  mode;
    logic [9:0]  scale;
    logic [15:0] speed;
    logic        fwd;
    logic        go;
  } tapo_cfg_s;

  typedef struct packed {
    logic plus;
    logic minus;
    logic busy;
  } tapo_out_s;

endpackage

// ### rtl/tapo_axis.sv
// One axis: rate generator and pulse encoder
`timescale 1ns/1ps
module tapo_axis
  import tapo_pkg::*;
(
  // Clock and reset
  input  wire logic      clock,
  input  wire logic      rst_b,
  input  wire logic      soft_rst,
  // Settings
  input  wire tapo_cfg_s cfg,
  input  wire logic      stop,
  // Pins
  output tapo_out_s      out
);

  tapo_state_e state;
  tapo_state_e next_state;
  logic [31:0] acc;
  logic [31:0] next_acc;
  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  logic        step;
  logic        next_step;
  logic        dir_fwd;
  logic        next_dir_fwd;
  logic        stop_pend;
  logic        next_stop_pend;
  logic [31:0] rate;
  logic [32:0] sum;

  // Speed units times scale gives pulses per second
  // Operands widened first so the product is not cut to 16 bits
  assign rate = 32'(cfg.speed) * 32'(cfg.scale);
  assign sum  = {1'b0, acc} + {1'b0, rate};

  always_comb begin
    next_state   = state;
    next_acc     = acc;
    next_cnt     = cnt;
    next_step    = step;
    next_dir_fwd = dir_fwd;
    next_stop_pend = stop_pend;
    if (cnt != 4'h0) begin
      next_cnt = cnt - 4'h1;
    end
    case (state)
      TAPO_IDLE: begin
        next_step = 1'b0;
        next_stop_pend = 1'b0;
        if (cfg.go) begin
          // Direction latched first so it settles ahead of any step
          next_dir_fwd = cfg.fwd;
          next_cnt     = DIR_SETUP_CYC;
          next_acc     = 32'h0;
          next_state   = TAPO_SETUP;
        end
      end
      TAPO_SETUP: begin
        if (stop) begin
          next_stop_pend = 1'b1;
        end
        if (cnt == 4'h0) begin
          next_state = TAPO_RUN;
        end
      end
      TAPO_RUN: begin
        if (cnt == 4'h0) begin
          next_step = 1'b0;
        end
        if (sum >= {1'b0, ACC_MODULUS}) begin
          next_acc  = 32'(sum - {1'b0, ACC_MODULUS});
          next_step = 1'b1;
          next_cnt  = PULSE_CYC;
        end else begin
          next_acc = sum[31:0];
        end
        // Stop is a one-cycle strobe; held so a step in flight cannot swallow it
        if (stop) begin
          next_stop_pend = 1'b1;
        end
        if ((stop || stop_pend) && !step) begin
          next_state     = TAPO_IDLE;
          next_stop_pend = 1'b0;
          next_step      = 1'b0;
          next_cnt       = 4'h0;
        end
      end
      default: next_state = TAPO_IDLE;
    endcase
    if (soft_rst) begin
      next_state = TAPO_IDLE;
      next_step  = 1'b0;
      next_cnt   = 4'h0;
      next_acc   = 32'h0;
      next_stop_pend = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state   <= TAPO_IDLE;
      acc     <= 32'h0;
      cnt     <= 4'h0;
      step    <= 1'b0;
      dir_fwd <= 1'b1;
      stop_pend <= 1'b0;
    end else begin
      state   <= next_state;
      acc     <= next_acc;
      cnt     <= next_cnt;
      step    <= next_step;
      dir_fwd <= next_dir_fwd;
      stop_pend <= next_stop_pend;
    end
  end

  // Output encoding, registered so pins are glitch free
  tapo_out_s next_out;
  always_comb begin
    next_out.busy  = (state != TAPO_IDLE);
    next_out.plus  = 1'b0;
    next_out.minus = 1'b0;
    case (cfg.mode)
      3'h0: begin
        next_out.plus  = step && dir_fwd;
        next_out.minus = step && !dir_fwd;
      end
      3'h1: begin
        next_out.plus  = !(step && dir_fwd);
        next_out.minus = !(step && !dir_fwd);
      end
      3'h2: begin
        next_out.plus  = step;
        next_out.minus = !dir_fwd;
      end
      3'h3: begin
        next_out.plus  = !step;
        next_out.minus = !dir_fwd;
      end
      3'h4: begin
        next_out.plus  = step;
        next_out.minus = dir_fwd;
      end
      3'h5: begin
        next_out.plus  = !step;
        next_out.minus = dir_fwd;
      end
      default: begin
        next_out.plus  = 1'b0;
        next_out.minus = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      out <= '0;
    end else begin
      out <= next_out;
    end
  end

endmodule

// ### rtl/tapo_top.sv
// Two-axis pulse output stage with AHB-Lite register slave
//
// Contract
// - Axis codes 1 first, 2 second, 3 both.
// - Both-axis commands apply to both simultaneously.
// - Modes 0/1 plus forward, minus reverse.
// - Modes 2-5 step plus, direction on minus.
// - Resolution is maximum speed over 8000.
// - Maximum speed capped at 4,000,000 PPS.
// - Maximum change rescales start, acceleration, jerk; the code rescales only the rate scale, having none of these.
// - Interpolation uses first axis maximum speed.
// - Software reset command restores initial state; the code leaves each axis dir_fwd latch unchanged.
`timescale 1ns/1ps
module tapo_top
  import tapo_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Motor driver pins
  output logic [1:0]       plus_pulse_out,
  output logic [1:0]       minus_pulse_out
);

  // Data phase capture
  logic       dp_wr;
  logic       next_dp_wr;
  logic [7:0] dp_addr;
  logic [7:0] next_dp_addr;
  logic [31:0] next_hrdata;

  // Settings per axis, plus shared interpolation and soft reset
  logic [2:0]  output_mode_select [2];
  logic [2:0]  next_mode          [2];
  logic [31:0] maxv               [2];
  logic [31:0] next_maxv          [2];
  logic [9:0]  scale              [2];
  logic [9:0]  next_scale         [2];
  logic [15:0] speed              [2];
  logic [15:0] next_speed         [2];
  logic [1:0]  go;
  logic [1:0]  next_go;
  logic [1:0]  stop;
  logic [1:0]  next_stop;
  logic [1:0]  fwd;
  logic [1:0]  next_fwd;
  logic        interp;
  logic        next_interp;
  logic        soft_rst;
  logic        next_soft_rst;
  tapo_out_s   aout [2];

  logic        addr_ok;
  logic [1:0]  cmd_axes;
  logic [3:0]  cmd_op;
  logic [23:0] cmd_arg;
  logic [31:0] clamp_v;

  assign addr_ok  = hsel && hready && htrans[1];
  assign cmd_axes = hwdata[CMD_AXIS_LSB +: 2];
  assign cmd_op   = hwdata[CMD_OP_LSB +: 4];
  assign cmd_arg  = hwdata[CMD_ARG_LSB +: 24];
  assign clamp_v  = (hwdata > MAXV_LIMIT) ? MAXV_LIMIT : hwdata;

  always_comb begin
    next_dp_wr    = addr_ok && hwrite;
    next_dp_addr  = addr_ok ? haddr[7:0] : dp_addr;
    next_go       = 2'h0;
    next_stop     = 2'h0;
    next_fwd      = fwd;
    next_interp   = interp;
    next_soft_rst = 1'b0;
    next_mode     = output_mode_select;
    next_maxv     = maxv;
    next_scale    = scale;
    next_speed    = speed;
    if (dp_wr) begin
      case (dp_addr)
        OFS_COMMAND: begin
          for (int i = 0; i < 2; i++) begin
            // One loop for both axes makes multi-axis writes simultaneous
            if (cmd_axes[i]) begin
              case (cmd_op)
                OP_MODE: next_mode[i] = cmd_arg[2:0];
                OP_MOVE: begin
                  next_go[i]  = 1'b1;
                  next_fwd[i] = cmd_arg[0];
                  next_speed[i] = cmd_arg[23:8];
                end
                OP_STOP: next_stop[i] = 1'b1;
                default: ;
              endcase
            end
          end
          if (cmd_op == OP_INTERP) begin
            next_interp = cmd_arg[0];
          end
          if (cmd_op == OP_RESET) begin
            next_soft_rst = 1'b1;
          end
        end
        OFS_MAXV0, OFS_MAXV1: begin
          for (int i = 0; i < 2; i++) begin
            if (dp_addr == ((i == 0) ? OFS_MAXV0 : OFS_MAXV1)) begin
              next_maxv[i]  = clamp_v;
              // Scale is integer PPS per speed unit; non-multiples truncate
              next_scale[i] = 10'(clamp_v / PPS_PER_UNIT);
              if (next_scale[i] == 10'h0) begin
                next_scale[i] = SCALE_RESET;
              end
            end
          end
        end
        OFS_SPEED0: next_speed[0] = hwdata[15:0];
        OFS_SPEED1: next_speed[1] = hwdata[15:0];
        default: ;
      endcase
    end
    if (soft_rst) begin
      for (int i = 0; i < 2; i++) begin
        next_mode[i]  = MODE_RESET;
        next_maxv[i]  = MAXV_RESET;
        next_scale[i] = SCALE_RESET;
        next_speed[i] = 16'h0;
      end
      next_fwd    = 2'h3;
      next_interp = 1'b0;
      next_go     = 2'h0;
    end
  end

  // Read mux, answered in the data phase cycle after address
  always_comb begin
    next_hrdata = 32'h0;
    if (addr_ok && !hwrite) begin
      case (haddr[7:0])
        OFS_MAXV0:  next_hrdata = maxv[0];
        OFS_MAXV1:  next_hrdata = maxv[1];
        OFS_SPEED0: next_hrdata = {16'h0, speed[0]};
        OFS_SPEED1: next_hrdata = {16'h0, speed[1]};
        OFS_STATUS: next_hrdata = {27'h0, interp, aout[1].busy, aout[0].busy,
                                   fwd};
        OFS_SCALE0: next_hrdata = {22'h0, scale[0]};
        OFS_SCALE1: next_hrdata = {22'h0, scale[1]};
        default:    next_hrdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dp_wr    <= 1'b0;
      dp_addr  <= 8'h0;
      hrdata   <= 32'h0;
      go       <= 2'h0;
      stop     <= 2'h0;
      fwd      <= 2'h3;
      interp   <= 1'b0;
      soft_rst <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        output_mode_select[i] <= MODE_RESET;
        maxv[i]               <= MAXV_RESET;
        scale[i]              <= SCALE_RESET;
        speed[i]              <= 16'h0;
      end
    end else begin
      dp_wr    <= next_dp_wr;
      dp_addr  <= next_dp_addr;
      hrdata   <= next_hrdata;
      go       <= next_go;
      stop     <= next_stop;
      fwd      <= next_fwd;
      interp   <= next_interp;
      soft_rst <= next_soft_rst;
      output_mode_select <= next_mode;
      maxv               <= next_maxv;
      scale              <= next_scale;
      speed              <= next_speed;
    end
  end

  // Always zero wait state, always OKAY
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_axis
      tapo_cfg_s c;
      always_comb begin
        c.mode  = output_mode_select[g];
        // Interpolation takes the rate scale of the first axis only
        c.scale = interp ? scale[0] : scale[g];
        c.speed = speed[g];
        c.fwd   = fwd[g];
        c.go    = go[g];
      end
      tapo_axis u_axis (
        .clock    (clock),
        .rst_b    (rst_b),
        .soft_rst (soft_rst),
        .cfg      (c),
        .stop     (stop[g]),
        .out      (aout[g])
      );
      assign plus_pulse_out[g]  = aout[g].plus;
      assign minus_pulse_out[g] = aout[g].minus;
    end
  endgenerate

endmodule

// ### tb/tapo_properties.sv
// Checker for the two-axis pulse output stage
`timescale 1ns/1ps
module tapo_properties
  import tapo_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_b,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Pins
  input wire logic [1:0]  plus_pulse_out,
  input wire logic [1:0]  minus_pulse_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic       cw;
  logic [2:0] m;
  logic       f;
  logic [3:0] q;
  logic [3:0] mq;
  // First axis mode and direction, snooped from commands
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cw <= 1'b0;
      m <= 3'h0;
      f <= 1'b1;
      q <= 4'h0;
      mq <= 4'h0;
    end else begin
      cw <= hsel && hready && htrans[1] && hwrite && haddr == 32'h0;
      q <= cw ? 4'h0 : q + 4'(q != 4'hF);
      // Mode switches move the pins too; settle before judging step edges
      mq <= (cw && (hwdata[7:4] == OP_RESET || (hwdata[0] && hwdata[7:4] == OP_MODE)))
        ? 4'h0 : mq + 4'(mq != 4'hF);
      if (cw && hwdata[0] && hwdata[7:4] == OP_MODE) m <= hwdata[10:8];
      if (cw && hwdata[0] && hwdata[7:4] == OP_MOVE) f <= hwdata[8];
      if (cw && hwdata[7:4] == OP_RESET) begin
        m <= 3'h0;
        f <= 1'b1;
      end
    end
  end
  AST_READY: assert property (hreadyout) else $error("wait state seen");
  AST_OKAY: assert property (!hresp) else $error("error response seen");
  AST_UNMAPPED: assert property (hsel && hready && htrans[1] && !hwrite && haddr > 32'h1C
    |=> hrdata == 32'h0) else $error("unmapped read not zero");
  AST_WIDTH_HI: assert property (!m[0] && m < 3'h6 && $rose(plus_pulse_out[0])
    |=> plus_pulse_out[0] [*8]) else $error("rising step too short");
  AST_WIDTH_LO: assert property (m[0] && m < 3'h6 && $fell(plus_pulse_out[0])
    |=> !plus_pulse_out[0] [*8]) else $error("falling step too short");
  AST_DIR_LEVEL: assert property (m > 3'h1 && m < 3'h6 && (m[0] ? $fell(plus_pulse_out[0])
    : $rose(plus_pulse_out[0])) |-> minus_pulse_out[0] == (m < 3'h4 ? !f : f))
    else $error("direction level wrong");
  AST_DIR_SETUP: assert property (mq == 4'hF && m > 3'h1 && m < 3'h6 && $changed(plus_pulse_out[0])
    |-> minus_pulse_out[0] == $past(minus_pulse_out[0], 8))
    else $error("direction not settled");
  AST_IDLE_PIN: assert property (m < 3'h2 && q == 4'hF
    |-> (f ? minus_pulse_out[0] : plus_pulse_out[0]) == m[0])
    else $error("idle pulse pin active");
  AST_SOFT_RST: assert property (cw && hwdata[7:4] == OP_RESET
    |-> ##[1:4] (plus_pulse_out == 2'h0 && minus_pulse_out == 2'h0))
    else $error("soft reset left pins");
  cover property ($rose(plus_pulse_out[0]));
  cover property (cw && hwdata[7:4] == OP_RESET);
  cover property (hsel && hready && htrans[1] && !hwrite && haddr > 32'h1C);
endmodule
bind tapo_top tapo_properties u_chk (.*);

// ### tb/tapo_drv.sv
// Motor driver model counting pin toggles
`timescale 1ns/1ps
module tapo_drv (
  // Clock and control
  input wire logic        clock,
  input wire logic        clr,
  // Pins
  input wire logic [1:0]  plus_in,
  input wire logic [1:0]  minus_in,
  // Counts
  output logic [15:0]     np [2],
  output logic [15:0]     nm [2]
);
  logic [1:0] pp;
  logic [1:0] pm;
  // Both edges counted, so a wrong polarity still shows
  always @(posedge clock) begin
    pp <= plus_in;
    pm <= minus_in;
    for (int i = 0; i < 2; i++) begin
      np[i] <= clr ? 16'h0 : np[i] + 16'(pp[i] != plus_in[i]);
      nm[i] <= clr ? 16'h0 : nm[i] + 16'(pm[i] != minus_in[i]);
    end
  end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the two-axis pulse output stage
`timescale 1ns/1ps
module tb_top;
  import tapo_pkg::*;
  logic        clock = 0, rst_b = 0, hsel = 0, hwrite = 0, clr = 0, dir;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, v;
  logic [1:0]  htrans = 0, plus_pulse_out, minus_pulse_out;
  logic [2:0]  hsize = 3'h2;
  logic        hready, hreadyout, hresp;
  logic [15:0] np [2], nm [2];
  logic [31:0] tbl [4] = '{32'h3E80, 32'h30D40, 32'h3D0900, 32'h4C4B40};
  int          fails = 0, checks = 0, cyc = 0, seed = 28, x;
  assign hready = hreadyout;
  always #12.5 clock = ~clock;
  tapo_top uut (.*);
  tapo_drv drv (.clock, .clr, .plus_in(plus_pulse_out), .minus_in(minus_pulse_out), .np, .nm);
  function automatic logic [31:0] scale_of(input logic [31:0] s);
    return (s > MAXV_LIMIT ? MAXV_LIMIT : s) / PPS_PER_UNIT;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic cmd(input logic [1:0] ax, input logic [3:0] op, input logic [23:0] arg);
    xfer(1'b1, OFS_COMMAND, {arg, op, 2'h0, ax});
  endtask
  task automatic summarize;
    if (fails == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    rchk(OFS_MAXV0, MAXV_RESET);
    rchk(OFS_SCALE1, 32'(SCALE_RESET));
    rchk(OFS_STATUS, 32'h3);
    rchk(8'h40, 32'h0);
    for (int i = 0; i < 8; i++) begin
      v = i < 4 ? tbl[i] : PPS_PER_UNIT * (1 + {$random(seed)} % 500);
      xfer(1'b1, i[0] ? OFS_MAXV1 : OFS_MAXV0, v);
      rchk(i[0] ? OFS_SCALE1 : OFS_SCALE0, scale_of(v));
      rchk(i[0] ? OFS_MAXV1 : OFS_MAXV0, v > MAXV_LIMIT ? MAXV_LIMIT : v);
    end
    xfer(1'b1, OFS_MAXV0, MAXV_LIMIT);
    xfer(1'b1, OFS_MAXV1, MAXV_LIMIT);
    cmd(BOTH_AXES_CODE, OP_MODE, 24'h2);
    cmd(BOTH_AXES_CODE, OP_MOVE, 24'h07D001);
    repeat (60) @(posedge clock);
    rchk(OFS_STATUS, 32'hF);
    cmd(BOTH_AXES_CODE, OP_STOP, 24'h0);
    repeat (30) @(posedge clock);
    for (int a = 1; a < 3; a++) begin
      for (int md = 0; md < 6; md++) begin
        dir = 1'($random(seed));
        x = a - 1;
        cmd(a[1:0], OP_MODE, 24'(md));
        repeat (20) @(posedge clock);
        clr <= 1'b1;
        @(posedge clock);
        clr <= 1'b0;
        cmd(a[1:0], OP_MOVE, {16'h07D0, 7'h0, dir});
        repeat (300) @(posedge clock);
        @(negedge clock);
        chk(32'(np[1 - x]), 32'h0);
        chk(32'(nm[1 - x]), 32'h0);
        if (md < 2) begin
          chk(32'(np[x] != 0), 32'(dir));
          chk(32'(nm[x] != 0), 32'(!dir));
        end else begin
          chk(32'(np[x] != 0), 32'h1);
          chk(32'(minus_pulse_out[x]), 32'(md < 4 ? !dir : dir));
        end
        cmd(a[1:0], OP_STOP, 24'h0);
        repeat (30) @(posedge clock);
      end
    end
    cmd(BOTH_AXES_CODE, OP_INTERP, 24'h1);
    xfer(1'b1, OFS_MAXV1, PPS_PER_UNIT);
    v = {16'h0, 16'($random(seed))};
    xfer(1'b1, OFS_SPEED0, v);
    rchk(OFS_SPEED0, v);
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk(32'(rd[4]), 32'h1);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    cmd(AXIS_SECOND_CODE, OP_MOVE, 24'h07D001);
    repeat (300) @(posedge clock);
    @(negedge clock);
    chk(32'(np[1] != 0), 32'h1);
    chk(32'(np[0]), 32'h0);
    cmd(AXIS_SECOND_CODE, OP_STOP, 24'h0);
    repeat (30) @(posedge clock);
    xfer(1'b1, OFS_MAXV0, 32'h3E80);
    cmd(BOTH_AXES_CODE, OP_RESET, 24'h0);
    repeat (4) @(posedge clock);
    rchk(OFS_MAXV0, MAXV_RESET);
    rchk(OFS_SCALE0, 32'h1);
    rchk(OFS_STATUS, 32'h3);
    summarize();
  end
endmodule
